// ### rsr_pkg.sv
// Package: register map, state codes and status carrier of the status bank
package rsr_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [5:0] RSR_ADDR_LINK_QUALITY  = 6'h33;
  localparam logic [5:0] RSR_ADDR_SIGNAL        = 6'h34;
  localparam logic [5:0] RSR_ADDR_RADIO_STATE   = 6'h35;
  localparam logic [5:0] RSR_ADDR_WAKE_HIGH     = 6'h36;
  localparam logic [5:0] RSR_ADDR_WAKE_LOW      = 6'h37;
  localparam logic [5:0] RSR_ADDR_PACKET        = 6'h38;
  localparam logic [5:0] RSR_ADDR_SYNTH_CAL     = 6'h39;
  localparam logic [5:0] RSR_ADDR_TX_QUEUE      = 6'h3A;
  localparam logic [5:0] RSR_ADDR_RX_QUEUE      = 6'h3B;

  // ==========================================================
  // Header byte fields
  localparam int RSR_HDR_READ_BIT  = 7;
  localparam int RSR_HDR_BURST_BIT = 6;
  localparam logic [2:0] RSR_LAST_BIT = 3'h7;
  localparam logic [7:0] RSR_ZERO_BYTE = 8'h00;
  localparam logic [2:0] RSR_RESERVED_STATE_BITS = 3'h0;

  // ==========================================================
  // Radio control state codes
  typedef enum logic [4:0] {
    RSR_ST_SLEEP        = 5'h00,
    RSR_ST_IDLE         = 5'h01,
    RSR_ST_CRYSTAL_OFF  = 5'h02,
    RSR_ST_MANUAL_CALIBRATION_STATE_VCO   = 5'h03,
    RSR_ST_MANUAL_CALIBRATION_STATE_REG   = 5'h04,
    RSR_ST_MANUAL_CALIBRATION_STATE       = 5'h05,
    RSR_ST_WAKE_VCO     = 5'h06,
    RSR_ST_WAKE_REG     = 5'h07,
    RSR_ST_CAL_START    = 5'h08,
    RSR_ST_SETTLE_BOOST = 5'h09,
    RSR_ST_SETTLE_LOCK  = 5'h0A,
    RSR_ST_SETTLE_ADC   = 5'h0B,
    RSR_ST_CAL_END      = 5'h0C,
    RSR_ST_RX           = 5'h0D,
    RSR_ST_RX_END       = 5'h0E,
    RSR_ST_RX_RESTART   = 5'h0F,
    RSR_ST_TX_TO_RX     = 5'h10,
    RSR_ST_RX_OVERFLOW  = 5'h11,
    RSR_ST_SYNTH_TX     = 5'h12,
    RSR_ST_TX           = 5'h13,
    RSR_ST_TX_END       = 5'h14,
    RSR_ST_RX_TO_TX     = 5'h15,
    RSR_ST_TX_UNDERFLOW = 5'h16
  } rsr_radio_state_t;

  // ==========================================================
  // Status carrier from the radio core
  typedef struct packed {
    logic [6:0]       link_quality_estimate;
    logic             lqi_valid;
    logic             crc_done;
    logic             crc_match;
    logic             rx_entry;
    logic [7:0]       signal_strength;
    rsr_radio_state_t radio_control_state;
    logic [15:0]      wake_time;
    logic             carrier_sense;
    logic             preamble_quality_flag;
    logic             channel_clear_flag;
    logic             sync_found_flag;
    logic             gp_output_two;
    logic             gp_output_one;
    logic             gp_output_zero;
    logic [7:0]       synth_tuning_setting;
    logic             tx_queue_underflow;
    logic [6:0]       tx_queue_level;
    logic             rx_queue_overflow;
    logic [6:0]       rx_queue_level;
  } rsr_status_t;

  // ==========================================================
  // Module state
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic       sclk_prev;
    logic [1:0] csn_sync;
    logic [1:0] mosi_sync;
    logic [2:0] bit_cnt;
    logic       hdr_done;
    logic [7:0] sh_in;
    logic [7:0] hdr;
    logic [7:0] sh_out;
    logic       miso;
    logic       crc_ok;
    logic [6:0] link_quality_status;
  } rsr_state_t;

  localparam rsr_state_t RSR_STATE_RST = '{csn_sync: 2'b11, default: '0};

endpackage : rsr_pkg

// ### rsr_status_bank.sv
// Read-only radio status register bank behind a serial port
`timescale 1ns/1ps

// Behaviour
// - Packet-check-ok bit 7 set on match; cleared on a mismatch or when receive entered or restarted.
// - Bits 6:0 carry latched link quality estimate over 64 symbols after sync.
// - Signal strength register is the full 8-bit live strength value.
// - Radio state register holds 5-bit state code; bits 7:5 read zero.
// - Wake timer bits 15:8 in high register, bits 7:0 in low register.
// - Packet status bits 6..3: carrier, preamble quality, clear channel, sync.
// - Packet status bits 2..0 show live levels of outputs two, one, zero.
// - Transmit status: underflow in bit 7, byte count in bits 6:0.
// - Receive status: overflow in bit 7, byte count in bits 6:0.
// - Synthesizer calibration tuning value readable as 8-bit test status.
module rsr_status_bank (
  // Clock and reset
  input  wire logic                SYS_CLK_I,
  input  wire logic                RST_N_I,
  // Serial port pins
  input  wire logic                SPI_CS_N_I,
  input  wire logic                SPI_SCLK_I,
  input  wire logic                SPI_MOSI_I,
  output logic                     SPI_MISO_O,
  output logic                     SPI_MISO_OE_O,
  // Status from the radio core
  input  wire rsr_pkg::rsr_status_t RADIO_STATUS_I
);
  import rsr_pkg::*;

  rsr_state_t st;
  rsr_state_t next_st;

  // ==========================================================
  // Register read decode
  function automatic logic [7:0] rsr_read(
    input logic [5:0]  addr,
    input rsr_status_t s,
    input logic        crc_ok,
    input logic [6:0]  link_quality_status
  );
    logic [7:0] v;
    v = RSR_ZERO_BYTE;
    case (addr)
      RSR_ADDR_LINK_QUALITY: begin
        v = {crc_ok, link_quality_status};
      end
      RSR_ADDR_SIGNAL: begin
        v = s.signal_strength;
      end
      RSR_ADDR_RADIO_STATE: begin
        v = {RSR_RESERVED_STATE_BITS, s.radio_control_state};
      end
      RSR_ADDR_WAKE_HIGH: begin
        v = s.wake_time[15:8];
      end
      RSR_ADDR_WAKE_LOW: begin
        v = s.wake_time[7:0];
      end
      RSR_ADDR_PACKET: begin
        v = {crc_ok, s.carrier_sense, s.preamble_quality_flag,
             s.channel_clear_flag, s.sync_found_flag,
             s.gp_output_two, s.gp_output_one, s.gp_output_zero};
      end
      RSR_ADDR_SYNTH_CAL: begin
        v = s.synth_tuning_setting;
      end
      RSR_ADDR_TX_QUEUE: begin
        v = {s.tx_queue_underflow, s.tx_queue_level};
      end
      RSR_ADDR_RX_QUEUE: begin
        v = {s.rx_queue_overflow, s.rx_queue_level};
      end
      default: begin
        v = RSR_ZERO_BYTE;
      end
    endcase
    return v;
  endfunction : rsr_read

  // ==========================================================
  // Next state
  logic       sclk_rise;
  logic       sclk_fall;
  logic       selected;
  logic [7:0] byte_in;
  logic [7:0] hdr_now;
  logic       is_read;
  logic [7:0] chk_state_byte;
  logic [7:0] chk_packet_byte;

  assign chk_state_byte  = rsr_read(RSR_ADDR_RADIO_STATE, RADIO_STATUS_I,
                                    st.crc_ok, st.link_quality_status);
  assign chk_packet_byte = rsr_read(RSR_ADDR_PACKET, RADIO_STATUS_I,
                                    st.crc_ok, st.link_quality_status);

  assign sclk_rise = st.sclk_sync[1] & ~st.sclk_prev;
  assign sclk_fall = ~st.sclk_sync[1] & st.sclk_prev;
  assign selected  = ~st.csn_sync[1];
  assign byte_in   = {st.sh_in[6:0], st.mosi_sync[1]};
  assign hdr_now   = st.hdr_done ? st.hdr : byte_in;
  assign is_read   = hdr_now[RSR_HDR_READ_BIT] & hdr_now[RSR_HDR_BURST_BIT];

  always_comb begin
    next_st = st;
    next_st.sclk_sync = {st.sclk_sync[0], SPI_SCLK_I};
    next_st.csn_sync  = {st.csn_sync[0], SPI_CS_N_I};
    next_st.mosi_sync = {st.mosi_sync[0], SPI_MOSI_I};
    next_st.sclk_prev = st.sclk_sync[1];
    // Packet check flag: a match wins over a receive entry
    if (RADIO_STATUS_I.crc_done && RADIO_STATUS_I.crc_match) begin
      next_st.crc_ok = 1'b1;
    end else if (RADIO_STATUS_I.crc_done || RADIO_STATUS_I.rx_entry) begin
      next_st.crc_ok = 1'b0;
    end
    if (RADIO_STATUS_I.lqi_valid) begin
      next_st.link_quality_status = RADIO_STATUS_I.link_quality_estimate;
    end
    // Serial transfer; write data only shifts in and is dropped
    if (!selected) begin
      next_st.bit_cnt  = '0;
      next_st.hdr_done = 1'b0;
      next_st.sh_out   = RSR_ZERO_BYTE;
      next_st.miso     = 1'b0;
    end else begin
      if (sclk_rise) begin
        next_st.sh_in   = byte_in;
        next_st.bit_cnt = st.bit_cnt + 3'h1;
        if (st.bit_cnt == RSR_LAST_BIT) begin
          next_st.hdr_done = 1'b1;
          next_st.hdr      = hdr_now;
          next_st.sh_out   = is_read ?
            rsr_read(hdr_now[5:0], RADIO_STATUS_I, st.crc_ok, st.link_quality_status) :
            RSR_ZERO_BYTE;
        end
      end else if (sclk_fall) begin
        next_st.miso   = st.sh_out[7];
        next_st.sh_out = {st.sh_out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      st <= RSR_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign SPI_MISO_O    = st.miso;
  assign SPI_MISO_OE_O = selected;

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_crc_set_match: assert property (
    RADIO_STATUS_I.crc_done && RADIO_STATUS_I.crc_match |=> st.crc_ok
  ) else $error("check flag not set on match");

  a_crc_clear_rx: assert property (
    RADIO_STATUS_I.rx_entry && !RADIO_STATUS_I.crc_done |=> !st.crc_ok
  ) else $error("check flag not cleared on rx entry");

  a_crc_hold: assert property (
    !RADIO_STATUS_I.rx_entry && !RADIO_STATUS_I.crc_done |=> $stable(st.crc_ok)
  ) else $error("check flag changed without cause");

  a_lqi_latch: assert property (
    RADIO_STATUS_I.lqi_valid |=>
      st.link_quality_status == $past(RADIO_STATUS_I.link_quality_estimate)
  ) else $error("quality estimate not latched");

  a_signal_strength_load: assert property (
    selected && sclk_rise && st.bit_cnt == RSR_LAST_BIT && is_read &&
    hdr_now[5:0] == RSR_ADDR_SIGNAL |=> st.sh_out == $past(RADIO_STATUS_I.signal_strength)
  ) else $error("strength byte not loaded");

  a_state_reserved: assert property (
    chk_state_byte[7:5] == RSR_RESERVED_STATE_BITS
  ) else $error("state reserved bits not zero");

  a_wake_split: assert property (
    {rsr_read(RSR_ADDR_WAKE_HIGH, RADIO_STATUS_I, st.crc_ok, st.link_quality_status),
     rsr_read(RSR_ADDR_WAKE_LOW, RADIO_STATUS_I, st.crc_ok, st.link_quality_status)}
      == RADIO_STATUS_I.wake_time
  ) else $error("wake timer bytes wrong");

  a_packet_flags: assert property (
    chk_packet_byte[6:0] ==
      {RADIO_STATUS_I.carrier_sense, RADIO_STATUS_I.preamble_quality_flag,
       RADIO_STATUS_I.channel_clear_flag, RADIO_STATUS_I.sync_found_flag,
       RADIO_STATUS_I.gp_output_two, RADIO_STATUS_I.gp_output_one,
       RADIO_STATUS_I.gp_output_zero}
  ) else $error("packet status bits wrong");

  a_queue_bytes: assert property (
    rsr_read(RSR_ADDR_TX_QUEUE, RADIO_STATUS_I, st.crc_ok, st.link_quality_status) ==
      {RADIO_STATUS_I.tx_queue_underflow, RADIO_STATUS_I.tx_queue_level} &&
    rsr_read(RSR_ADDR_RX_QUEUE, RADIO_STATUS_I, st.crc_ok, st.link_quality_status) ==
      {RADIO_STATUS_I.rx_queue_overflow, RADIO_STATUS_I.rx_queue_level}
  ) else $error("queue status bytes wrong");

  a_synth_read: assert property (
    rsr_read(RSR_ADDR_SYNTH_CAL, RADIO_STATUS_I, st.crc_ok, st.link_quality_status) ==
      RADIO_STATUS_I.synth_tuning_setting
  ) else $error("tuning value wrong");

  a_write_no_data: assert property (
    selected && sclk_rise && st.bit_cnt == RSR_LAST_BIT && !is_read
      |=> st.sh_out == RSR_ZERO_BYTE
  ) else $error("write access loaded read data");

endmodule : rsr_status_bank

// ### rsr_host_model.sv
// Host model that reads the status bank over the serial port
`timescale 1ns/1ps
module rsr_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial port pins
  input  wire logic miso_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // ==========================================================
  // Header byte then one data byte, mode 0, MSB first
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, dat};
    rd = '0;
    @(posedge clk_i) #1;
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = sh[i];
      repeat (4) @(posedge clk_i);
      #1 sclk_o = 1'b1;
      repeat (4) @(posedge clk_i);
      if (i < 8) begin
        rd[i] = miso_i;
      end
      #1 sclk_o = 1'b0;
    end
    repeat (4) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : xfer
endmodule : rsr_host_model

// ### testbench.sv
// Self-checking testbench of the status bank
`timescale 1ns/1ps
module testbench;
  import rsr_pkg::*;
  logic        sys_clk      = 1'b0;
  logic        rst_n        = 1'b0;
  logic        cs_n;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  rsr_status_t st           = '0;
  int          err_count    = 0;
  int          total_checks = 0;
  logic [7:0]  rd;

  always #20 sys_clk = ~sys_clk;

  rsr_status_bank u_dut (
    .SYS_CLK_I      (sys_clk),
    .RST_N_I        (rst_n),
    .SPI_CS_N_I     (cs_n),
    .SPI_SCLK_I     (sclk),
    .SPI_MOSI_I     (mosi),
    .SPI_MISO_O     (miso),
    .SPI_MISO_OE_O  (miso_oe),
    .RADIO_STATUS_I (st)
  );

  rsr_host_model u_host (
    .clk_i  (sys_clk),
    .miso_i (miso),
    .cs_n_o (cs_n),
    .sclk_o (sclk),
    .mosi_o (mosi)
  );

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
    u_host.xfer({2'b11, a}, 8'h00, rd);
    chk($sformatf("reg %h", a), exp, rd);
  endtask : rd_reg

  task automatic pulse(input logic done, input logic match,
                       input logic entry);
    @(posedge sys_clk) #1;
    st.crc_done  = done;
    st.crc_match = match;
    st.rx_entry  = entry;
    @(posedge sys_clk) #1;
    st.crc_done  = 1'b0;
    st.rx_entry  = 1'b0;
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic test_fields;
    @(posedge sys_clk) #1;
    st.link_quality_estimate = 7'h5A;
    st.lqi_valid             = 1'b1;
    st.signal_strength                  = 8'hA5;
    st.wake_time             = 16'h3C96;
    st.carrier_sense         = 1'b1;
    st.channel_clear_flag    = 1'b1;
    st.gp_output_two         = 1'b1;
    st.gp_output_zero        = 1'b1;
    st.synth_tuning_setting  = 8'h6B;
    st.tx_queue_underflow    = 1'b1;
    st.tx_queue_level        = 7'h2A;
    st.rx_queue_level        = 7'h41;
    @(posedge sys_clk) #1;
    st.lqi_valid             = 1'b0;
    st.link_quality_estimate = 7'h11;
    rd_reg(RSR_ADDR_LINK_QUALITY, 8'h5A);
    rd_reg(RSR_ADDR_SIGNAL, 8'hA5);
    rd_reg(RSR_ADDR_WAKE_HIGH, 8'h3C);
    rd_reg(RSR_ADDR_WAKE_LOW, 8'h96);
    rd_reg(RSR_ADDR_PACKET, 8'h55);
    rd_reg(RSR_ADDR_SYNTH_CAL, 8'h6B);
    rd_reg(RSR_ADDR_TX_QUEUE, 8'hAA);
    rd_reg(RSR_ADDR_RX_QUEUE, 8'h41);
    st.gp_output_one         = 1'b1;
    st.rx_queue_overflow     = 1'b1;
    rd_reg(RSR_ADDR_PACKET, 8'h57);
    rd_reg(RSR_ADDR_RX_QUEUE, 8'hC1);
    $display("test_fields done");
  endtask : test_fields

  task automatic test_states;
    for (int s = 0; s <= 22; s++) begin
      st.radio_control_state = rsr_radio_state_t'(s);
      rd_reg(RSR_ADDR_RADIO_STATE, {3'h0, 5'(s)});
    end
    $display("test_states done");
  endtask : test_states

  task automatic test_crc;
    pulse(1'b1, 1'b1, 1'b0);
    rd_reg(RSR_ADDR_LINK_QUALITY, 8'hDA);
    rd_reg(RSR_ADDR_PACKET, 8'hD7);
    pulse(1'b0, 1'b0, 1'b1);
    rd_reg(RSR_ADDR_LINK_QUALITY, 8'h5A);
    rd_reg(RSR_ADDR_PACKET, 8'h57);
    pulse(1'b1, 1'b1, 1'b1);
    rd_reg(RSR_ADDR_LINK_QUALITY, 8'hDA);
    pulse(1'b0, 1'b0, 1'b1);
    rd_reg(RSR_ADDR_LINK_QUALITY, 8'h5A);
    $display("test_crc done");
  endtask : test_crc

  task automatic test_write;
    u_host.xfer(8'h34, 8'hFF, rd);
    chk("write reply", 8'h00, rd);
    u_host.xfer(8'h78, 8'h00, rd);
    rd_reg(RSR_ADDR_SIGNAL, 8'hA5);
    rd_reg(RSR_ADDR_PACKET, 8'h57);
    rd_reg(6'h3C, 8'h00);
    u_host.xfer(8'hB4, 8'h00, rd);
    chk("single read", 8'h00, rd);
    chk("port idle", 8'h00, {6'h00, miso_oe, miso});
    $display("test_write done");
  endtask : test_write

  // ==========================================================
  // Verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    test_fields();
    test_states();
    test_crc();
    test_write();
    test_done();
  end

  initial begin
    #3000000;
    err_count++;
    test_done();
  end
endmodule : testbench
